// >>> core/msc_regs.svh
/*
 * register map, field positions, reset values and frame length bounds of
 * the mac statistics counter bank.
 * assumes a 32-bit wishbone data path with byte addresses.
 */
`ifndef MSC_REGS_SVH
`define MSC_REGS_SVH

`define MSC_ADR_W 8
`define MSC_OFS_NET_CTRL 8'h00
`define MSC_OFS_NET_CFG 8'h04
`define MSC_OFS_TYPE_ID 8'h08
`define MSC_OFS_USER_IO 8'h0c
`define MSC_OFS_CNT_BASE 8'h10
`define MSC_CNT_NUM 9

`define MSC_CTRL_RX_EN 2
`define MSC_CTRL_STAT_WE 7
`define MSC_CFG_BIG_FRAMES 8
`define MSC_USRIO_RMII 0
`define MSC_USRIO_TRANSCEIVER_CLOCK_ENABLE 1
`define MSC_TID_W 16

`define MSC_RST_VAL 32'h0000_0000
`define MSC_LEN_MIN 11'h040
`define MSC_LEN_MAX 11'h5ee
`define MSC_LEN_MAX_BIG 11'h600
`define MSC_MULTI_COLL_MAX 5'h0f

`define MSC_W_PAUSE 16
`define MSC_W_TX_OK 24
`define MSC_W_SCOL 16
`define MSC_W_MCOL 16
`define MSC_W_RX_OK 24
`define MSC_W_CRC 8
`define MSC_W_ALIGN 8
`define MSC_W_DEFER 16
`define MSC_W_LATE 8

`endif

// >>> core/msc_pkg.sv
/*
 * types shared by the statistics counter bank.
 * assumes msc_regs.svh supplies the numbers.
 */
`include "msc_regs.svh"

package msc_pkg;
    // counter slots, in address order from the counter base
    typedef enum {
        msc_pause_ok, msc_tx_ok, msc_single_col, msc_multi_col, msc_rx_ok,
        msc_crc_err, msc_align_err, msc_deferred, msc_late_col
    } msc_cnt_t;
    typedef logic [23:0] msc_cnt_val_t;
    typedef logic [10:0] msc_len_t;
endpackage

// >>> core/msc_stats.sv
/*
 * statistics counters of an ethernet mac with their wishbone register
 * file, type id compare and transceiver interface select / clock gate.
 * assumes frame status strobes come from the mac on the same clock, one
 * pulse per finished frame with its status valid in that cycle.
 */
// Behaviour
// - counters clear when read and stick at all ones.
// - receive counters advance only while receive enable is set.
// - counter writes take effect only with control bit 7 set.
// - user io bit 0 selects rmii when one, mii when zero.
// - user io bit 1 passes transceiver clock when one, blocks otherwise.
// - 16-bit count of good pause frames, 64 to max length, error free.
// - max valid length 1518, or 1536 with config bit 8.
// - 24-bit count of frames sent with no underrun and retries within limit.
// - 16-bit count of frames sent after exactly one collision.
// - 16-bit count of frames sent after two to fifteen collisions.
// - 24-bit count of good, address matched, fully copied frames.
// - 8-bit count of whole-byte valid-length frames with bad crc.
// - crc counter also counts symbol errors on whole-byte valid frames.
// - 8-bit count of valid frames with dribble bits and bad crc.
// - alignment counter also counts symbol errors on dribble frames.
// - 16-bit count of first-attempt deferrals, no collision nor underrun.
// - 8-bit count of late collisions, also counted as collisions.
// - stored type id compared with each received type/length field.
`timescale 1ns/1ps
`include "msc_regs.svh"

module msc_stats (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [`MSC_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // receive frame status
    input wire logic rx_done,
    input wire msc_pkg::msc_len_t rx_len,
    input wire logic rx_dribble,
    input wire logic rx_crc_bad,
    input wire logic rx_symbol_err,
    input wire logic rx_addr_match,
    input wire logic rx_copied,
    input wire logic rx_pause,
    input wire logic [15:0] rx_type_len,
    // transmit frame status
    input wire logic tx_done,
    input wire logic tx_underrun,
    input wire logic tx_retry_exceeded,
    input wire logic [4:0] tx_collisions,
    input wire logic tx_deferred,
    input wire logic tx_late_collision,
    // transceiver side
    input wire logic phy_clk_in,
    output logic phy_clk_gated,
    output logic rmii_mode,
    output logic type_id_match
);

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic int cnt_width(input int i);
        case (i)
            0: cnt_width = `MSC_W_PAUSE;
            1: cnt_width = `MSC_W_TX_OK;
            2: cnt_width = `MSC_W_SCOL;
            3: cnt_width = `MSC_W_MCOL;
            4: cnt_width = `MSC_W_RX_OK;
            5: cnt_width = `MSC_W_CRC;
            6: cnt_width = `MSC_W_ALIGN;
            7: cnt_width = `MSC_W_DEFER;
            default: cnt_width = `MSC_W_LATE;
        endcase
    endfunction

    function automatic logic cnt_hit(input logic [`MSC_ADR_W-1:0] a,
                                     input int i);
        cnt_hit = a == (`MSC_OFS_CNT_BASE + `MSC_ADR_W'(4 * i));
    endfunction

    // byte lanes not selected keep their old contents
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0] sel);
        merge = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                merge[8*b +: 8] = new_v[8*b +: 8];
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // wishbone slave: ack one edge after the request is seen

    logic ack_r;
    logic req;
    logic rd_cap;
    logic wr_do;
    logic [31:0] ctrl_r;
    logic [31:0] cfg_r;
    logic [31:0] tid_r;
    logic [31:0] usrio_r;
    logic [`MSC_CNT_NUM-1:0][23:0] cnt_w;
    logic [`MSC_CNT_NUM-1:0] inc;
    logic [31:0] rd_mux;

    assign req = wb_cyc_i && wb_stb_i;
    // reads sample and clear in the same edge so no increment slips between
    assign rd_cap = req && !ack_r && !wb_we_i;
    // writes land on the edge where the master sees ack
    assign wr_do = req && ack_r && wb_we_i;
    assign wb_ack_o = ack_r;

    always_ff @(posedge clk) begin
        if (reset) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req && !ack_r;
        end
    end

    always_comb begin
        rd_mux = `MSC_RST_VAL;
        case (wb_adr_i)
            `MSC_OFS_NET_CTRL: rd_mux = ctrl_r;
            `MSC_OFS_NET_CFG: rd_mux = cfg_r;
            `MSC_OFS_TYPE_ID: rd_mux = tid_r;
            `MSC_OFS_USER_IO: rd_mux = usrio_r;
            default: rd_mux = `MSC_RST_VAL;
        endcase
        for (int i = 0; i < `MSC_CNT_NUM; i++) begin
            if (cnt_hit(wb_adr_i, i)) begin
                rd_mux = {8'h00, cnt_w[i]};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            wb_dat_o <= `MSC_RST_VAL;
        end else if (rd_cap) begin
            wb_dat_o <= rd_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control registers; unused bits read as zero

    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl_r <= `MSC_RST_VAL;
            cfg_r <= `MSC_RST_VAL;
            tid_r <= `MSC_RST_VAL;
            usrio_r <= `MSC_RST_VAL;
        end else if (wr_do) begin
            case (wb_adr_i)
                `MSC_OFS_NET_CTRL: begin
                    ctrl_r <= merge(ctrl_r, wb_dat_i, wb_sel_i) &
                        32'h0000_0084;
                end
                `MSC_OFS_NET_CFG: begin
                    cfg_r <= merge(cfg_r, wb_dat_i, wb_sel_i) &
                        32'h0000_0100;
                end
                `MSC_OFS_TYPE_ID: begin
                    tid_r <= merge(tid_r, wb_dat_i, wb_sel_i) &
                        32'h0000_ffff;
                end
                `MSC_OFS_USER_IO: begin
                    usrio_r <= merge(usrio_r, wb_dat_i, wb_sel_i) &
                        32'h0000_0003;
                end
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transceiver interface

    assign rmii_mode = usrio_r[`MSC_USRIO_RMII];
    // plain and gate: transceiver_clock_enable should only change while the phy clock is low
    assign phy_clk_gated = phy_clk_in && usrio_r[`MSC_USRIO_TRANSCEIVER_CLOCK_ENABLE];

    always_ff @(posedge clk) begin
        if (reset) begin
            type_id_match <= 1'b0;
        end else if (rx_done) begin
            type_id_match <=
                rx_type_len == tid_r[`MSC_TID_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // frame qualification

    logic rx_en;
    logic rx_ev;
    logic len_ok;
    logic rx_good;
    logic rx_bad;
    logic tx_ok;
    msc_pkg::msc_len_t len_max;

    assign rx_en = ctrl_r[`MSC_CTRL_RX_EN];
    assign rx_ev = rx_done && rx_en;
    assign len_max = cfg_r[`MSC_CFG_BIG_FRAMES] ?
        `MSC_LEN_MAX_BIG : `MSC_LEN_MAX;
    assign len_ok = rx_len >= `MSC_LEN_MIN && rx_len <= len_max;
    assign rx_good = len_ok && !rx_crc_bad && !rx_symbol_err;
    assign rx_bad = len_ok && (rx_crc_bad || rx_symbol_err);
    assign tx_ok = tx_done && !tx_underrun && !tx_retry_exceeded;

    always_comb begin
        inc = '0;
        inc[msc_pkg::msc_pause_ok] = rx_ev && rx_pause && rx_good;
        inc[msc_pkg::msc_tx_ok] = tx_ok;
        inc[msc_pkg::msc_single_col] = tx_ok && tx_collisions == 5'h01;
        inc[msc_pkg::msc_multi_col] = tx_ok && tx_collisions >= 5'h02 &&
            tx_collisions <= `MSC_MULTI_COLL_MAX;
        inc[msc_pkg::msc_rx_ok] = rx_ev && rx_good && rx_addr_match &&
            rx_copied;
        inc[msc_pkg::msc_crc_err] = rx_ev && !rx_dribble &&
            rx_bad;
        inc[msc_pkg::msc_align_err] = rx_ev && rx_dribble &&
            rx_bad;
        inc[msc_pkg::msc_deferred] = tx_done && tx_deferred &&
            tx_collisions == 5'h00 && !tx_underrun;
        inc[msc_pkg::msc_late_col] = tx_done && tx_late_collision;
    end

    ////////////////////////////////////////////////////////////////////////
    // counter bank; a write in the same cycle as an increment wins

    for (genvar gi = 0; gi < `MSC_CNT_NUM; gi++) begin : g_cnt
        localparam int W = cnt_width(gi);
        localparam logic [23:0] MAXV = 24'((1 << W) - 1);
        logic hit;
        logic [23:0] val_r;
        logic [31:0] wr_merged;

        assign hit = cnt_hit(wb_adr_i, gi);
        assign cnt_w[gi] = val_r;
        assign wr_merged = merge({8'h00, val_r}, wb_dat_i, wb_sel_i);

        always_ff @(posedge clk) begin
            if (reset) begin
                val_r <= 24'h000000;
            end else if (rd_cap && hit) begin
                val_r <= inc[gi] ? 24'h000001 : 24'h000000;
            end else if (wr_do && hit && ctrl_r[`MSC_CTRL_STAT_WE]) begin
                val_r <= wr_merged[23:0] & MAXV;
            end else if (inc[gi] && val_r != MAXV) begin
                val_r <= val_r + 24'h000001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions

    logic quiet;
    assign quiet = !req;

    sequence s_read_cap(int i);
        rd_cap && cnt_hit(wb_adr_i, i);
    endsequence

    property p_read_clear;
        @(posedge clk) disable iff (reset)
        s_read_cap(5) ##0 !inc[5] |=> cnt_w[5] == 24'h0;
    endproperty
    a_read_clear: assert property (p_read_clear)
        else $error("crc counter not cleared by read");

    property p_saturate;
        @(posedge clk) disable iff (reset)
        quiet && cnt_w[5] == 24'h0000ff && inc[5] |=>
            cnt_w[5] == 24'h0000ff;
    endproperty
    a_saturate: assert property (p_saturate)
        else $error("crc counter wrapped");

    property p_rx_gate;
        @(posedge clk) disable iff (reset)
        quiet && !rx_en |=> $stable(cnt_w[4]) && $stable(cnt_w[0]);
    endproperty
    a_rx_gate: assert property (p_rx_gate)
        else $error("rx counter moved while receive disabled");

    property p_wr_block;
        @(posedge clk) disable iff (reset)
        wr_do && cnt_hit(wb_adr_i, 5) && !ctrl_r[`MSC_CTRL_STAT_WE] &&
            !inc[5] |=> $stable(cnt_w[5]);
    endproperty
    a_wr_block: assert property (p_wr_block)
        else $error("counter write not blocked");

    property p_rmii_sel;
        @(posedge clk) disable iff (reset)
        wr_do && wb_adr_i == `MSC_OFS_USER_IO && wb_sel_i[0] |=>
            rmii_mode == $past(wb_dat_i[`MSC_USRIO_RMII]);
    endproperty
    a_rmii_sel: assert property (p_rmii_sel)
        else $error("rmii select not taken from write");

    property p_clk_gate;
        @(posedge clk) disable iff (reset)
        !usrio_r[`MSC_USRIO_TRANSCEIVER_CLOCK_ENABLE] |-> !phy_clk_gated;
    endproperty
    a_clk_gate: assert property (p_clk_gate)
        else $error("transceiver clock passed while disabled");

    property p_pause_step;
        @(posedge clk) disable iff (reset)
        quiet && rx_done && rx_en && rx_pause && rx_len == `MSC_LEN_MIN &&
            !rx_crc_bad && !rx_symbol_err && cnt_w[0] != 24'h00ffff |=>
            cnt_w[0] == $past(cnt_w[0]) + 24'h1;
    endproperty
    a_pause_step: assert property (p_pause_step)
        else $error("good pause frame not counted once");

    property p_len_bound;
        @(posedge clk) disable iff (reset)
        quiet && !cfg_r[`MSC_CFG_BIG_FRAMES] && rx_len == 11'h5f0 |->
            !inc[5] && !inc[6] && !inc[0];
    endproperty
    a_len_bound: assert property (p_len_bound)
        else $error("overlong frame counted");

    property p_single_col;
        @(posedge clk) disable iff (reset)
        tx_ok && tx_collisions == 5'h01 |-> inc[2] && !inc[3];
    endproperty
    a_single_col: assert property (p_single_col)
        else $error("single collision misclassified");

    property p_read_race;
        @(posedge clk) disable iff (reset)
        s_read_cap(1) ##0 inc[1] |=> cnt_w[1] == 24'h1 && wb_ack_o &&
            wb_dat_o == {8'h00, $past(cnt_w[1])};
    endproperty
    a_read_race: assert property (p_read_race)
        else $error("increment lost during read");

endmodule // msc_stats

// >>> tb/msc_phy_model.sv
/*
 * transceiver stand-in: supplies the free running input clock that the
 * counter bank gates on to the transceiver side.
 * assumes nothing of the bench clock; phase is unrelated on purpose.
 */
`timescale 1ns/1ps

module msc_phy_model (
    // transceiver clock
    output logic phy_clk
);
    // 25 mhz, as an mii transceiver would run; never phase locked to clk
    initial begin
        phy_clk = 1'b0;
        #3.1;
        forever #20 phy_clk = ~phy_clk;
    end
endmodule // msc_phy_model

// >>> tb/test_mac_statistics_counters.sv
/*
 * bench of the statistics counter bank: random frame status against an
 * integer model, register access over classic wishbone.
 * assumes msc_phy_model drives the transceiver clock.
 */
`timescale 1ns/1ps

module test_mac_statistics_counters;
    logic clk, reset, cyc, stb, we, ack, ph, phg, rmii, tidm;
    logic rd, drb, crc, sym, am, cp, pse, td, und, rty, dfr, lt;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] di, dq, q;
    logic [10:0] len;
    logic [15:0] tl;
    logic [4:0] col;
    int n_errors, cmp_count, r;
    int m[9];
    int w[9] = '{16, 24, 16, 16, 24, 8, 8, 16, 8};
    bit rxen, big;

    msc_stats dut (.clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(di),
        .wb_dat_o(dq), .wb_ack_o(ack), .rx_done(rd), .rx_len(len),
        .rx_dribble(drb), .rx_crc_bad(crc), .rx_symbol_err(sym),
        .rx_addr_match(am), .rx_copied(cp), .rx_pause(pse),
        .rx_type_len(tl), .tx_done(td), .tx_underrun(und),
        .tx_retry_exceeded(rty), .tx_collisions(col), .tx_deferred(dfr),
        .tx_late_collision(lt), .phy_clk_in(ph), .phy_clk_gated(phg),
        .rmii_mode(rmii), .type_id_match(tidm));
    msc_phy_model u_phy (.phy_clk(ph));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task test_done;
        $display("compares %0d errors %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // entered right after a rising edge; waits for ack without a fixed count
    task bus(input logic w_, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w_;
        adr <= a;
        di <= d;
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1'b1 && k < 50);
        chk(32'(ack), 32'h1);
        q = dq;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask

    task rdc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(q, e);
    endtask

    function void inc(input int i);
        if (m[i] != (1 << w[i]) - 1)
            m[i]++;
    endfunction

    task chkall;
        for (int i = 0; i < 9; i++) begin
            rdc(8'h10 + 8'(4 * i), m[i]);
            m[i] = 0;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    task rxf(input int l, input bit d, c, s, a, p, k, input logic [15:0] t);
        bit vl, g;
        rd <= 1'b1;
        len <= l[10:0];
        drb <= d;
        crc <= c;
        sym <= s;
        am <= a;
        cp <= k;
        pse <= p;
        tl <= t;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        vl = l >= 64 && l <= (big ? 1536 : 1518);
        g = vl && !c && !s;
        if (rxen) begin
            if (g && p) inc(0);
            if (g && a && k) inc(4);
            if (vl && (c || s) && !d) inc(5);
            if (vl && (c || s) && d) inc(6);
        end
    endtask

    task txf;
        int n;
        bit u, rt, df, lc;
        n = $urandom % 17;
        u = ($urandom % 4) == 0;
        rt = n == 16;
        df = $urandom % 2;
        lc = n > 0 && ($urandom % 2);
        td <= 1'b1;
        col <= n[4:0];
        und <= u;
        rty <= rt;
        dfr <= df;
        lt <= lc;
        @(posedge clk);
        td <= 1'b0;
        @(posedge clk);
        if (!u && !rt) inc(1);
        if (n == 1 && !u) inc(2);
        if (n >= 2 && n <= 15 && !u && !rt) inc(3);
        if (df && n == 0 && !u) inc(7);
        if (lc) inc(8);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        int lt_tab[6] = '{63, 64, 1518, 1519, 1536, 1537};
        int l;
        {cyc, stb, we, rd, drb, crc, sym, am, cp, pse} = '0;
        {td, und, rty, dfr, lt, adr, di, len, tl, col} = '0;
        sel = 4'hf;
        reset = 1'b1;
        void'($urandom(85));
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        chkall();
        chk(32'(rmii), 32'h0);
        bus(1'b1, 8'h0c, 32'h1);
        chk(32'(rmii), 32'h1);
        for (int i = 0; i < 6; i++) begin
            #7.3;
            chk(32'(phg), 32'h0);
        end
        @(posedge clk);
        bus(1'b1, 8'h0c, 32'h2);
        chk(32'(rmii), 32'h0);
        for (int i = 0; i < 6; i++) begin
            #7.3;
            chk(32'(phg), 32'(ph));
        end
        @(posedge clk);
        rdc(8'h40, 32'h0);
        for (r = 0; r < 4; r++) begin
            rxen = r != 1;
            big = r >= 2;
            bus(1'b1, 8'h00, {29'h0, rxen, 2'b00});
            bus(1'b1, 8'h04, {23'h0, big, 8'h00});
            repeat (80) begin
                l = ($urandom % 3 == 0) ? lt_tab[$urandom % 6]
                                        : 40 + $urandom % 1560;
                if ($urandom % 2)
                    txf();
                else
                    rxf(l, $urandom, $urandom % 3 == 0, $urandom % 4 == 0,
                        $urandom, $urandom, $urandom, 16'($urandom));
            end
            chkall();
        end
        // writes without the enable bit must leave the counter alone
        bus(1'b1, 8'h00, 32'h4);
        bus(1'b1, 8'h24, 32'hfe);
        rdc(8'h24, 32'h0);
        bus(1'b1, 8'h00, 32'h84);
        bus(1'b1, 8'h24, 32'hfe);
        m[5] = 254;
        repeat (3) rxf(100, 0, 1, 0, 0, 0, 0, 16'h0);
        rdc(8'h24, 32'hff);
        m[5] = 0;
        bus(1'b1, 8'h14, 32'hffff_ffff);
        rdc(8'h14, 32'h00ff_ffff);
        bus(1'b1, 8'h08, 32'h0000_88f7);
        rxf(100, 0, 0, 0, 0, 0, 0, 16'h88f7);
        chk(32'(tidm), 32'h1);
        rxf(100, 0, 0, 0, 0, 0, 0, 16'h88f6);
        chk(32'(tidm), 32'h0);
        // a clean transmit status in the very edge that takes a read
        {und, rty, dfr, lt, col} <= '0;
        fork
            rdc(8'h14, m[1]);
            begin
                td <= 1'b1;
                @(posedge clk);
                td <= 1'b0;
            end
        join
        m[1] = 1;
        chkall();
        test_done();
    end

    // the tests need about a thousand cycles; this is forty thousand, far beyond that
    initial begin
        #200_000;
        n_errors++;
        test_done();
    end
endmodule // test_mac_statistics_counters
